/* File: common/dmr_defines.svh */
/*
 * Constants of the mode register bank: command decode, field positions,
 * calibration codes and timing counts.
 * Assumes a 40 MHz core clock.
 */
`ifndef DMR_DEFINES_SVH
`define DMR_DEFINES_SVH

`define DMR_ADDR_W          13
`define DMR_SEL_MAIN        2'h0
`define DMR_SEL_EXT1        2'h1
`define DMR_SEL_EXT2        2'h2
`define DMR_SEL_EXT3        2'h3

`define DMR_BL_LSB          0
`define DMR_BT_BIT          3
`define DMR_CL_LSB          4
`define DMR_TM_BIT          7
`define DMR_DLLRST_BIT      8
`define DMR_WR_LSB          9

`define DMR_DLLDIS_BIT      0
`define DMR_RDRV_BIT        1
`define DMR_TERM0_BIT       2
`define DMR_AL_LSB          3
`define DMR_TERM1_BIT       6
`define DMR_CAL_LSB         7
`define DMR_NDQS_BIT        10

`define DMR_DCC_BIT         3
`define DMR_HTSR_BIT        7

`define DMR_CAL_EXIT        3'h0
`define DMR_CAL_DRV1        3'h1
`define DMR_CAL_DRV0        3'h2
`define DMR_CAL_ADJ         3'h4
`define DMR_CAL_DFLT        3'h7

`define DMR_BL_4            3'h2
`define DMR_BL_8            3'h3

`define DMR_STEP_MAX        4'hf
`define DMR_STEP_DFLT       4'h8

`define DMR_DLL_LOCK_CYC    200

`endif

/* File: common/dmr_pkg.sv */
/*
 * Types of the mode register bank.
 * Assumes dmr_defines.svh is available on the include path.
 */
package dmr_pkg;
    typedef enum logic [1:0] {
        DMR_DRV_OFF,
        DMR_DRV_ONE,
        DMR_DRV_ZERO
    } dmr_drv_t;

    typedef enum logic [1:0] {
        DMR_CAL_IDLE,
        DMR_CAL_ADJ_WAIT
    } dmr_cal_st_t;
endpackage : dmr_pkg

/* File: common/dmr_burst_if.sv */
/*
 * Carrier between the register bank and its burst address sequencer.
 * Assumes one clock domain; all signals are levels.
 */
`timescale 1ns/1ps
interface dmr_burst_if;
    logic       len8;
    logic       interleave;
    logic [2:0] start;
    logic [2:0] beat;
    logic [2:0] col;

    modport bank (output len8, output interleave, output start,
                  output beat, input col);
    modport seq  (input len8, input interleave, input start,
                  input beat, output col);
endinterface : dmr_burst_if

/* File: rtl/dmr_burst_seq.sv */
/*
 * Burst column ordering: returns the low column bits of a given beat.
 * Assumes the caller holds start, beat and mode steady for the lookup.
 */
`timescale 1ns/1ps
module dmr_burst_seq
    import dmr_pkg::*;
(
    dmr_burst_if.seq bi
);
    logic [2:0] seq_col;
    logic [1:0] low_sum;

    always_comb
    begin
        low_sum = bi.start[1:0] + bi.beat[1:0];
        // Sequential wraps within a group of four, then the other group
        seq_col = {bi.start[2] ^ bi.beat[2], low_sum};
        if (!bi.len8)
        begin
            seq_col[2] = bi.start[2];
        end
    end

    always_comb
    begin
        if (bi.interleave)
        begin
            bi.col = bi.start ^ (bi.len8 ? bi.beat
                                         : {1'b0, bi.beat[1:0]});
        end
        else
        begin
            bi.col = seq_col;
        end
    end
endmodule : dmr_burst_seq

/* File: rtl/dmr_mode_regs.sv */
/*
 * Mode register bank of a four-bank DDR2 device: command decode, the four
 * mode registers, field outputs, calibration drive modes, strength steps,
 * DLL lock counting and burst ordering lookup.
 * Assumes command pins arrive from the pad ring asynchronous to core_clk_i
 * and are synchronised here; the controller keeps its own timing rules.
 */
// Notes on behaviour
// - Command lows with CKE high and both bank bits low load the main register.
// - Registers may be rewritten anytime while banks idle.
// - Main fields: burst length, burst type, read latency; no half clocks.
// - Main A7 is test mode, written low; A8 requests DLL reset.
// - Burst of four: sequential wraps modulo four, interleave XORs.
// - Burst of eight: sequential wraps inside group of four; interleave XORs.
// - Leaving self refresh re-enables the DLL automatically.
// - Extended register one loads with bank bit one low, bit zero high.
// - Extended one fields: DLL off, drive, latency, calibration, strobe, term.
// - Extended two loads with bank bits 1,0 = 1,0; A7 hot refresh, A3 DCC.
// - Drive-1 drives data and strobe high; Drive-0 drives them low.
// - Calibration codes: exit, drive-1, drive-0, adjust, default.
// - Both bank bits high selects extended register three.
// - Strength spans sixteen steps; codes beyond limits change nothing.
`timescale 1ns/1ps
`include "dmr_defines.svh"
module dmr_mode_regs
    import dmr_pkg::*;
#(
    parameter int ADDR_W   = `DMR_ADDR_W,
    parameter int LOCK_CYC = `DMR_DLL_LOCK_CYC
)
(
    // Clock, reset, enable
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              clk_en_i,
    // Command pins
    input  wire logic              cs_n_i,
    input  wire logic              ras_n_i,
    input  wire logic              cas_n_i,
    input  wire logic              we_n_i,
    input  wire logic              cke_i,
    input  wire logic              bank_select_0_i,
    input  wire logic              bank_select_1_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    // Events from the core
    input  wire logic              self_refresh_exit_i,
    input  wire logic              cal_beat_i,
    input  wire logic [3:0]        cal_code_i,
    input  wire logic [2:0]        burst_start_i,
    input  wire logic [2:0]        burst_beat_i,
    // Register contents
    output logic [ADDR_W-1:0]      main_mode_o,
    output logic [ADDR_W-1:0]      ext_one_o,
    output logic [ADDR_W-1:0]      ext_two_o,
    output logic [ADDR_W-1:0]      ext_three_o,
    // Decoded fields
    output logic [2:0]             burst_len_o,
    output logic                   interleave_o,
    output logic [2:0]             read_latency_o,
    output logic                   test_mode_o,
    output logic [2:0]             write_recovery_o,
    output logic [2:0]             additive_latency_o,
    output logic                   reduced_drive_o,
    output logic [1:0]             on_die_termination_o,
    output logic                   strobe_n_disable_o,
    output logic                   hot_refresh_o,
    output logic                   duty_cycle_corrector_o,
    // DLL and driver state, burst column
    output logic                   dll_enable_o,
    output logic                   dll_reset_o,
    output logic                   dll_locked_o,
    output logic                   drive_en_o,
    output logic                   dq_level_o,
    output logic                   dqs_level_o,
    output logic                   dqs_n_level_o,
    output logic [3:0]             pullup_step_o,
    output logic [3:0]             pulldown_step_o,
    output logic [2:0]             burst_col_o
);
    initial
    begin
        if (ADDR_W != 13 || LOCK_CYC < 1 || LOCK_CYC > 65535)
        begin
            $error("dmr_mode_regs: unsupported parameters");
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int PW = ADDR_W + 7;
    logic [PW-1:0] pin_meta;
    logic [PW-1:0] pin_sync;
    logic [PW-1:0] pin_raw;

    assign pin_raw = {cs_n_i, ras_n_i, cas_n_i, we_n_i, cke_i,
                      bank_select_1_i, bank_select_0_i, addr_i};

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pin_meta <= '1;
            pin_sync <= '1;
        end
        else if (clk_en_i)
        begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    logic              s_cs_n;
    logic              s_ras_n;
    logic              s_cas_n;
    logic              s_we_n;
    logic              s_cke;
    logic [1:0]        s_bank;
    logic [ADDR_W-1:0] s_addr;

    assign {s_cs_n, s_ras_n, s_cas_n, s_we_n, s_cke, s_bank, s_addr} =
        pin_sync;

    // ------------------------------------------------------------
    // Command decode and register load
    // ------------------------------------------------------------
    logic load_cmd;
    assign load_cmd = !s_cs_n && !s_ras_n && !s_cas_n && !s_we_n
                      && s_cke;

    logic [ADDR_W-1:0] next_main;
    logic [ADDR_W-1:0] next_ext1;
    logic [ADDR_W-1:0] next_ext2;
    logic [ADDR_W-1:0] next_ext3;

    always_comb
    begin
        next_main = main_mode_o;
        next_ext1 = ext_one_o;
        next_ext2 = ext_two_o;
        next_ext3 = ext_three_o;
        if (load_cmd)
        begin
            unique case (s_bank)
                `DMR_SEL_MAIN: next_main = s_addr;
                `DMR_SEL_EXT1: next_ext1 = s_addr;
                `DMR_SEL_EXT2: next_ext2 = s_addr;
                `DMR_SEL_EXT3: next_ext3 = s_addr;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            main_mode_o <= '0;
            ext_one_o   <= '0;
            ext_two_o   <= '0;
            ext_three_o <= '0;
        end
        else if (clk_en_i)
        begin
            main_mode_o <= next_main;
            ext_one_o   <= next_ext1;
            ext_two_o   <= next_ext2;
            ext_three_o <= next_ext3;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    assign burst_len_o      = main_mode_o[`DMR_BL_LSB +: 3];
    assign interleave_o     = main_mode_o[`DMR_BT_BIT];
    assign read_latency_o   = main_mode_o[`DMR_CL_LSB +: 3];
    assign test_mode_o      = main_mode_o[`DMR_TM_BIT];
    assign write_recovery_o = main_mode_o[`DMR_WR_LSB +: 3];
    assign additive_latency_o = ext_one_o[`DMR_AL_LSB +: 3];
    assign reduced_drive_o  = ext_one_o[`DMR_RDRV_BIT];
    assign on_die_termination_o = {ext_one_o[`DMR_TERM1_BIT],
                                   ext_one_o[`DMR_TERM0_BIT]};
    assign strobe_n_disable_o = ext_one_o[`DMR_NDQS_BIT];
    assign hot_refresh_o    = ext_two_o[`DMR_HTSR_BIT];
    assign duty_cycle_corrector_o = ext_two_o[`DMR_DCC_BIT];

    // ------------------------------------------------------------
    // DLL enable, reset and lock count
    // ------------------------------------------------------------
    logic        main_load;
    logic        ext1_load;
    logic        dll_dis_q;
    logic        next_dll_dis;
    logic [15:0] lock_cnt;
    logic [15:0] next_lock_cnt;
    logic        next_dll_rst;

    assign main_load = load_cmd && s_bank == `DMR_SEL_MAIN;
    assign ext1_load = load_cmd && s_bank == `DMR_SEL_EXT1;

    always_comb
    begin
        next_dll_dis = dll_dis_q;
        if (ext1_load)
        begin
            next_dll_dis = s_addr[`DMR_DLLDIS_BIT];
        end
        if (self_refresh_exit_i)
        begin
            next_dll_dis = 1'b0;
        end
        next_dll_rst = main_load && s_addr[`DMR_DLLRST_BIT];
        next_lock_cnt = lock_cnt;
        if (next_dll_dis || next_dll_rst || self_refresh_exit_i ||
            (dll_dis_q && !next_dll_dis))
        begin
            next_lock_cnt = '0;
        end
        else if (lock_cnt != 16'(LOCK_CYC))
        begin
            next_lock_cnt = lock_cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dll_dis_q   <= 1'b1;
            dll_reset_o <= 1'b0;
            lock_cnt    <= '0;
        end
        else if (clk_en_i)
        begin
            dll_dis_q   <= next_dll_dis;
            dll_reset_o <= next_dll_rst;
            lock_cnt    <= next_lock_cnt;
        end
    end

    assign dll_enable_o = !dll_dis_q;
    assign dll_locked_o = lock_cnt == 16'(LOCK_CYC);

    // ------------------------------------------------------------
    // Driver calibration modes and strength steps
    // ------------------------------------------------------------
    dmr_drv_t    drv_q;
    dmr_drv_t    next_drv;
    dmr_cal_st_t cal_q;
    dmr_cal_st_t next_cal;
    logic [3:0]  pu_q;
    logic [3:0]  pd_q;
    logic [3:0]  next_pu;
    logic [3:0]  next_pd;
    logic [2:0]  cal_field;
    logic        pu_inc;
    logic        pu_dec;
    logic        pd_inc;
    logic        pd_dec;

    assign cal_field = s_addr[`DMR_CAL_LSB +: 3];

    always_comb
    begin
        pu_inc = 1'b0;
        pu_dec = 1'b0;
        pd_inc = 1'b0;
        pd_dec = 1'b0;
        unique case (cal_code_i)
            4'h1: pu_inc = 1'b1;
            4'h2: pu_dec = 1'b1;
            4'h4: pd_inc = 1'b1;
            4'h8: pd_dec = 1'b1;
            4'h5: {pu_inc, pd_inc} = 2'h3;
            4'h6: {pu_dec, pd_inc} = 2'h3;
            4'h9: {pu_inc, pd_dec} = 2'h3;
            4'ha: {pu_dec, pd_dec} = 2'h3;
            default: ;
        endcase
    end

    always_comb
    begin
        next_drv = drv_q;
        next_cal = cal_q;
        next_pu  = pu_q;
        next_pd  = pd_q;
        if (ext1_load)
        begin
            unique case (cal_field)
                `DMR_CAL_EXIT: begin next_drv = DMR_DRV_OFF;
                                     next_cal = DMR_CAL_IDLE; end
                `DMR_CAL_DRV1: next_drv = DMR_DRV_ONE;
                `DMR_CAL_DRV0: next_drv = DMR_DRV_ZERO;
                `DMR_CAL_ADJ:  next_cal = DMR_CAL_ADJ_WAIT;
                `DMR_CAL_DFLT: begin next_pu = `DMR_STEP_DFLT;
                                     next_pd = `DMR_STEP_DFLT; end
                default: ;
            endcase
        end
        else if (cal_q == DMR_CAL_ADJ_WAIT && cal_beat_i)
        begin
            // Saturate at the ends of the step range
            if (pu_inc && pu_q != `DMR_STEP_MAX) next_pu = pu_q + 4'h1;
            if (pu_dec && pu_q != 4'h0) next_pu = pu_q - 4'h1;
            if (pd_inc && pd_q != `DMR_STEP_MAX) next_pd = pd_q + 4'h1;
            if (pd_dec && pd_q != 4'h0) next_pd = pd_q - 4'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            drv_q <= DMR_DRV_OFF;
            cal_q <= DMR_CAL_IDLE;
            pu_q  <= `DMR_STEP_DFLT;
            pd_q  <= `DMR_STEP_DFLT;
        end
        else if (clk_en_i)
        begin
            drv_q <= next_drv;
            cal_q <= next_cal;
            pu_q  <= next_pu;
            pd_q  <= next_pd;
        end
    end

    assign drive_en_o      = drv_q != DMR_DRV_OFF;
    assign dq_level_o      = drv_q == DMR_DRV_ONE;
    assign dqs_level_o     = drv_q == DMR_DRV_ONE;
    assign dqs_n_level_o   = drv_q == DMR_DRV_ZERO;
    assign pullup_step_o   = pu_q;
    assign pulldown_step_o = pd_q;

    // ------------------------------------------------------------
    // Burst ordering lookup
    // ------------------------------------------------------------
    dmr_burst_if bif ();
    assign bif.len8       = burst_len_o == `DMR_BL_8;
    assign bif.interleave = interleave_o;
    assign bif.start      = burst_start_i;
    assign bif.beat       = burst_beat_i;
    assign burst_col_o    = bif.col;

    dmr_burst_seq u_seq (
        .bi (bif)
    );

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    main_load_a: assert property (clk_en_i && main_load |=>
        main_mode_o == $past(s_addr))
        else $error("main register did not capture address");
    ext1_load_a: assert property (clk_en_i && ext1_load |=>
        ext_one_o == $past(s_addr))
        else $error("extended one did not capture address");
    ext2_sel_a: assert property (clk_en_i && load_cmd && s_bank == 2'h2
        |=> ext_two_o == $past(s_addr) && $stable(main_mode_o))
        else $error("extended two load wrong");
    ext3_sel_a: assert property (clk_en_i && load_cmd && s_bank == 2'h3
        |=> ext_three_o == $past(s_addr) && $stable(ext_one_o))
        else $error("extended three load wrong");
    reg_hold_a: assert property (!load_cmd |=> $stable(main_mode_o)
        && $stable(ext_two_o))
        else $error("register changed without load");
    srx_dll_a: assert property (clk_en_i && self_refresh_exit_i
        |=> dll_enable_o && !dll_locked_o)
        else $error("self refresh exit did not enable DLL");
    drive_one_a: assert property (clk_en_i && ext1_load
        && cal_field == 3'h1 |=> drive_en_o && dq_level_o
        && !dqs_n_level_o)
        else $error("drive-1 levels wrong");
    step_lim_a: assert property (pu_q == 4'hf && cal_q == DMR_CAL_ADJ_WAIT
        && cal_beat_i && cal_code_i == 4'h1 && !ext1_load
        |=> pullup_step_o == 4'hf)
        else $error("pull-up step passed its limit");
    cal_exit_a: assert property (clk_en_i && ext1_load && cal_field == 3'h0
        |=> !drive_en_o ##1 !drive_en_o || $past(ext1_load))
        else $error("calibration exit left driver on");
    seq_ilv_a: assert property (bif.len8 && bif.interleave |->
        (burst_col_o ^ burst_start_i) == burst_beat_i)
        else $error("interleaved burst column wrong");

    load_main_c: cover property (clk_en_i && main_load);
    adj_step_c:  cover property (cal_q == DMR_CAL_ADJ_WAIT && cal_beat_i);
    drv0_c:      cover property (dqs_n_level_o);
    lock_c:      cover property (dll_locked_o);
endmodule : dmr_mode_regs

/* File: dv/dmr_ctrl_model.sv */
/*
 * Controller model: turns one load request into a load command on the pins.
 * Assumes requests come one at a time, with all banks idle.
 */
`timescale 1ns/1ps
module dmr_ctrl_model
#(
    parameter int GAP = 5
)
(
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // Load request
    input  wire logic        req_i,
    input  wire logic [1:0]  sel_i,
    input  wire logic [12:0] addr_i,
    output logic             busy_o,
    // Command pins
    output logic             cs_n_o,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic [1:0]       bank_o,
    output logic [12:0]      addr_o
);
    logic [3:0]  cnt;
    logic [12:0] keep;

    always_comb
    begin
        case (sel_i)
            2'h0:    keep = 13'h1f7f;
            2'h1:    keep = 13'h17ff;
            2'h2:    keep = 13'h0088;
            default: keep = 13'h0000;
        endcase
    end

    assign busy_o = (cnt != 4'h0);

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hf;
            bank_o <= 2'h0;
            addr_o <= 13'h0000;
            cnt    <= 4'h0;
        end
        else if (req_i && cnt == 4'h0)
        begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'h0;
            bank_o <= sel_i;
            addr_o <= addr_i & keep;
            cnt    <= 4'(GAP);
        end
        else
        begin
            // Deselected lines do not keep their last value
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= 4'hf;
            bank_o <= ~bank_o;
            addr_o <= ~addr_o;
            if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
        end
    end
endmodule : dmr_ctrl_model

/* File: dv/ddr2_mode_register_programming_test.sv */
/*
 * Bench of the mode register bank: a controller model loads registers,
 * a bench model predicts every output. Assumes a 40 MHz core clock.
 */
`timescale 1ns/1ps
module ddr2_mode_register_programming_test;
    logic        clk, rst_n, cke, req, cal_beat, sr_exit, seen, ce;
    logic        cs_n, ras_n, cas_n, we_n, busy;
    logic        ilv, tm, rdrv, ndqs, hot, dcc;
    logic        dll_en, dll_rst, lock, drv, dq, dqs, dqs_n;
    logic [1:0]  sel, bank, on_die_termination;
    logic [2:0]  bst, bbt, blen, rl, wr, al, col, e, msk;
    logic [3:0]  cal_code, pu, pd, c;
    logic [12:0] a, pa, mm, e1, e2, e3, v;
    logic [12:0] m [4];
    logic [3:0]  tbl [9];
    int          err_total, num_checks, seed, mpu, mpd, i, k, s, b, n;
    int          dc [5];

    dmr_ctrl_model u_dmr_ctrl_model (
        .core_clk_i (clk), .rst_n_i (rst_n), .req_i (req), .sel_i (sel),
        .addr_i (a), .busy_o (busy), .cs_n_o (cs_n), .ras_n_o (ras_n),
        .cas_n_o (cas_n), .we_n_o (we_n), .bank_o (bank), .addr_o (pa));

    dmr_mode_regs #(.LOCK_CYC (4)) u_dmr_mode_regs (
        .core_clk_i (clk), .rst_n_i (rst_n), .clk_en_i (ce),
        .cs_n_i (cs_n), .ras_n_i (ras_n), .cas_n_i (cas_n),
        .we_n_i (we_n), .cke_i (cke), .bank_select_0_i (bank[0]),
        .bank_select_1_i (bank[1]), .addr_i (pa),
        .self_refresh_exit_i (sr_exit), .cal_beat_i (cal_beat),
        .cal_code_i (cal_code), .burst_start_i (bst), .burst_beat_i (bbt),
        .main_mode_o (mm), .ext_one_o (e1), .ext_two_o (e2),
        .ext_three_o (e3), .burst_len_o (blen), .interleave_o (ilv),
        .read_latency_o (rl), .test_mode_o (tm), .write_recovery_o (wr),
        .additive_latency_o (al), .reduced_drive_o (rdrv),
        .on_die_termination_o (on_die_termination), .strobe_n_disable_o (ndqs),
        .hot_refresh_o (hot), .duty_cycle_corrector_o (dcc),
        .dll_enable_o (dll_en), .dll_reset_o (dll_rst),
        .dll_locked_o (lock), .drive_en_o (drv), .dq_level_o (dq),
        .dqs_level_o (dqs), .dqs_n_level_o (dqs_n),
        .pullup_step_o (pu), .pulldown_step_o (pd), .burst_col_o (col));

    // ----------------------------------------------------------------
    // Clock and helpers
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
        if (dll_rst === 1'b1)
            seen <= 1'b1;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    function automatic logic [12:0] keep(input logic [1:0] sl);
        return (sl == 2'h0) ? 13'h1f7f : (sl == 2'h1) ? 13'h17ff :
               (sl == 2'h2) ? 13'h0088 : 13'h0000;
    endfunction : keep

    task automatic load(input logic [1:0] sl, input logic [12:0] val);
        int w;
        @(posedge clk);
        req  <= 1'b1;
        sel  <= sl;
        a    <= val;
        seen <= 1'b0;
        if (cke === 1'b1 && ce === 1'b1)
            m[sl] = val & keep(sl);
        @(posedge clk);
        req <= 1'b0;
        #1;
        for (w = 0; w < 20 && busy !== 1'b0; w++)
        begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'b0)
        begin
            check(busy, 1'b0);
            finish_test();
        end
        check(mm, m[0]);
        check(e1, m[1]);
        check(e2, m[2]);
        check(e3, m[3]);
        check({blen, ilv, rl, wr, tm}, {m[0][2:0], m[0][3], m[0][6:4],
              m[0][11:9], m[0][7]});
        check({al, rdrv, on_die_termination, ndqs}, {m[1][5:3], m[1][1], m[1][6],
              m[1][2], m[1][10]});
        check({hot, dcc}, {m[2][7], m[2][3]});
        if (sl == 2'h0)
            check(seen, val[8] & cke & ce);
    endtask : load

    task automatic pulse_cal(input logic [3:0] code);
        @(posedge clk);
        cal_beat <= 1'b1;
        cal_code <= code;
        @(posedge clk);
        cal_beat <= 1'b0;
        @(posedge clk);
        #1;
    endtask : pulse_cal

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {rst_n, cke, req, cal_beat, sr_exit, seen, ce} = 7'h1;
        {sel, a, cal_code, bst, bbt} = 25'h0;
        {err_total, num_checks, mpu, mpd} = {32'h0, 32'h0, 32'h8, 32'h8};
        seed = 32'h5fb73fb9;
        tbl = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h5, 4'h6, 4'h9, 4'ha, 4'h3};
        dc = '{1, 0, 2, 0, 3};
        for (i = 0; i < 4; i++)
            m[i] = 13'h0000;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        cke   <= 1'b1;
        #1;
        check({drv, dll_en, lock, pu, pd}, {3'h0, 4'h8, 4'h8});
        load(2'h2, 13'h0000);
        load(2'h3, 13'h0000);
        load(2'h1, 13'h0000);
        check(lock, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        check(lock, 1'b1);
        load(2'h0, 13'h0100);
        $display("test init done");
        for (i = 0; i < 16; i++)
        begin
            v = 13'($random(seed));
            b = i[1:0] ^ 2'($random(seed));
            if (b == 1)
                v[9:7] = 3'h0;
            load(2'(b), v);
        end
        cke <= 1'b0;
        load(2'h0, ~m[0]);
        cke <= 1'b1;
        $display("test reprogram done");
        for (k = 0; k < 4; k++)
        begin
            n   = k[1] ? 8 : 4;
            msk = k[1] ? 3'h7 : 3'h3;
            load(2'h0, {6'h00, 3'h4, k[0], k[1] ? 3'h3 : 3'h2});
            for (s = 0; s < n * n; s++)
            begin
                @(posedge clk);
                bst <= 3'(s / n);
                bbt <= 3'(s % n);
                @(posedge clk);
                #1;
                e = k[0] ? (bst ^ bbt) : ((bst ^ bbt) & 3'h4) |
                    ((bst + bbt) & 3'h3);
                check(col & msk, e & msk);
            end
        end
        $display("test burst done");
        for (i = 0; i < 5; i++)
        begin
            load(2'h1, 13'(dc[i]) << 7);
            check(drv, dc[i] == 1 || dc[i] == 2);
            if (dc[i] == 1 || dc[i] == 2)
                check({dq, dqs, dqs_n}, dc[i] == 1 ? 3'h6 : 3'h1);
        end
        load(2'h0, 13'h0042);
        load(2'h1, 13'h0200);
        for (i = 0; i < 40; i++)
        begin
            c = (i < 9) ? 4'h1 : (i < 26) ? 4'h8 :
                tbl[$unsigned($random(seed)) % 9];
            pulse_cal(c);
            mpu += (c == 1 || c == 5 || c == 9) - (c == 2 || c == 6 || c == 10);
            mpd += (c == 4 || c == 5 || c == 6) - (c == 8 || c == 9 || c == 10);
            mpu = (mpu > 15) ? 15 : (mpu < 0) ? 0 : mpu;
            mpd = (mpd > 15) ? 15 : (mpd < 0) ? 0 : mpd;
            check({pu, pd}, {4'(mpu), 4'(mpd)});
        end
        load(2'h1, 13'h0000);
        check({pu, pd}, {4'(mpu), 4'(mpd)});
        load(2'h1, 13'h0380);
        check({pu, pd}, 8'h88);
        load(2'h1, 13'h0000);
        $display("test calibration done");
        load(2'h1, 13'h0001);
        check(dll_en, 1'b0);
        @(posedge clk);
        sr_exit <= 1'b1;
        @(posedge clk);
        sr_exit <= 1'b0;
        @(posedge clk);
        #1;
        check(dll_en, 1'b1);
        $display("test self refresh done");
        ce <= 1'b0;
        load(2'h0, 13'h0100);
        ce <= 1'b1;
        rst_n <= 1'b0;
        m = '{default: 13'h0000};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check({drv, dll_en, lock, pu, pd}, {3'h0, 8'h88});
        load(2'h2, 13'h0080);
        $display("test clock enable and reset done");
        finish_test();
    end
endmodule : ddr2_mode_register_programming_test
